// ---- dv/rcr_config_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module rcr_config_asserts #(
    parameter int NCHAN = 8,
    parameter int WIN_S = 180
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Host bytes
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready,
    // Radio
    input wire logic pkt_ready,
    input wire logic chan_busy,
    input wire logic [7:0] chan_index,
    input wire logic air_done,
    input wire logic radio_tx,
    input wire logic sense_req,
    // Power
    input wire logic wake,
    input wire logic vol_corrupt,
    input wire logic radio_en,
    input wire logic asleep,
    input wire logic soft_reset,
    input wire logic [1:0] rcr_sense_mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    a_tx_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte dropped");
    a_off_no_sense: assert property (rcr_sense_mode == 2'h0 && !sense_req |=> !sense_req)
        else $error("sensing in mode 0");
    a_off_at_once: assert property (rcr_sense_mode == 2'h0 && pkt_ready && radio_en && !radio_tx
        |-> ##[1:2] radio_tx) else $error("mode 0 send late");
    a_free_only: assert property ($rose(radio_tx) && rcr_sense_mode != 2'h0 |-> !$past(chan_busy))
        else $error("sent on busy channel");
    a_sleep_dark: assert property (asleep |-> !radio_en && !radio_tx && !sense_req)
        else $error("circuitry on in sleep");
    a_tx_awake: assert property (radio_tx |-> radio_en)
        else $error("send while not awake");
    a_reboot_pulse: assert property (soft_reset |=> !soft_reset)
        else $error("reboot pulse too long");
    a_corrupt_boot: assert property (asleep && wake && vol_corrupt |-> ##[1:3] soft_reset)
        else $error("no reboot on corruption");
    a_clean_wake: assert property (asleep && wake && !vol_corrupt |=> !soft_reset [*3])
        else $error("reboot on clean wake");
    a_wake_up: assert property (asleep && wake |-> ##[1:3] !asleep)
        else $error("wake ignored");
endmodule
`default_nettype wire

// ---- dv/rcr_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rcr_host_model (
    // Clock
    input wire logic mclk,
    // Toward device
    output logic rx_valid,
    output logic [7:0] rx_data,
    // From device
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    int stall = 2;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b0;
    end
    // One frame byte; idle data inverted
    task automatic put(input logic [7:0] v);
        @(posedge mclk);
        #1;
        rx_valid = 1'b1;
        rx_data = v;
        @(posedge mclk);
        #1;
        rx_valid = 1'b0;
        rx_data = ~v;
    endtask
    // Slow accept of one reply byte
    task automatic get(output logic [7:0] v, output bit ok);
        ok = 1'b0;
        v = 'x;
        for (int i = 0; i < 60 && !ok; i++) begin
            @(posedge mclk);
            #1;
            ok = (tx_valid === 1'b1);
        end
        if (ok) begin
            v = tx_data;
            repeat (stall) @(posedge mclk);
            #1;
            tx_ready = 1'b1;
            @(posedge mclk);
            #1;
            tx_ready = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ---- dv/tb_radio_config_registers.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_radio_config_registers;
    import rcr_pkg::*;
    logic mclk, reset, rx_valid, tx_valid, tx_ready, pkt_ready, chan_busy, air_done;
    logic radio_tx, sense_req, wake, vol_corrupt, radio_en, asleep, soft_reset;
    logic [7:0] rx_data, tx_data, chan_index, b, lb;
    logic [1:0] rcr_sense_mode;
    int error_cnt = 0;
    int checks_done = 0;
    int n;
    bit ok;
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    rcr_config_top #(.NCHAN(8), .WIN_S(1)) u_dut (.mclk(mclk), .reset(reset),
        .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .pkt_ready(pkt_ready), .chan_busy(chan_busy),
        .chan_index(chan_index), .air_done(air_done), .radio_tx(radio_tx),
        .sense_req(sense_req), .wake(wake), .vol_corrupt(vol_corrupt), .radio_en(radio_en),
        .asleep(asleep), .soft_reset(soft_reset), .rcr_sense_mode(rcr_sense_mode));
    rcr_host_model u_host (.mclk(mclk), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic take(input logic [7:0] exp);
        u_host.get(b, ok);
        if (!ok) begin
            error_cnt++;
            $display("BAD %0t: no reply", $time);
            report_and_stop();
        end
        chk(b, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        u_host.put(HDR_BYTE);
        u_host.put(SIZE_BYTE);
        u_host.put(a);
        u_host.put(v);
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] v);
        u_host.put(HDR_BYTE);
        u_host.put(SIZE_BYTE);
        u_host.put(ESC_BYTE);
        u_host.put(a);
        take(ACK_BYTE);
        take(a);
        take(v);
    endtask
    task automatic drain();
        n = 0;
        ok = 1'b1;
        while (ok) begin
            u_host.get(b, ok);
            if (ok) begin
                n++;
                lb = b;
            end
        end
    endtask
    task automatic wait_tx();
        for (int i = 0; i < 50 && radio_tx !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        chk({7'h00, radio_tx}, 8'h01);
        if (radio_tx !== 1'b1) report_and_stop();
    endtask
    task automatic pulse_wake(input logic bad);
        vol_corrupt = bad;
        wake = 1'b1;
        @(posedge mclk);
        #1;
        wake = 1'b0;
        vol_corrupt = 1'b0;
    endtask
    initial begin
        repeat (40000) @(posedge mclk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        {reset, pkt_ready, chan_busy, air_done, wake, vol_corrupt} = 6'h20;
        chan_index = 8'h03;
        repeat (4) @(posedge mclk);
        #1;
        chk({6'h00, radio_en, asleep}, 8'h02);
        reset = 1'b0;
        drain();
        chk(8'(n), 8'(BANNER_LEN + 1));
        chk(lb, ACK_BYTE);
        rd(ADDR_BANNER_NV, BANNER_ON);
        wr(ADDR_SENSE, SENSE_FREE);
        chk({6'h00, rcr_sense_mode}, 8'h01);
        wr(ADDR_SENSE, 8'h03);
        rd(ADDR_SENSE, SENSE_FREE);
        chan_busy = 1'b1;
        pkt_ready = 1'b1;
        repeat (20) @(posedge mclk);
        #1;
        chk({7'h00, radio_tx}, 8'h00);
        chan_busy = 1'b0;
        wait_tx();
        {pkt_ready, air_done} = 2'b01;
        wr(ADDR_SENSE, SENSE_OFF);
        {pkt_ready, air_done, chan_busy} = 3'b101;
        wait_tx();
        chk({7'h00, sense_req}, 8'h00);
        {pkt_ready, air_done, chan_busy} = 3'b010;
        wr(ADDR_SENSE_NV, SENSE_POLICED);
        rd(ADDR_SENSE_NV, SENSE_POLICED);
        wr(ADDR_SENSE, SENSE_FREE);
        wr(ADDR_POWER, 8'h02);
        rd(ADDR_POWER, POWER_AWAKE);
        wr(ADDR_POWER, POWER_SLEEP);
        chk({6'h00, radio_en, asleep}, 8'h01);
        pulse_wake(1'b0);
        drain();
        rd(ADDR_SENSE, SENSE_FREE);
        rd(ADDR_POWER, POWER_AWAKE);
        wr(ADDR_BANNER_NV, BANNER_OFF);
        wr(ADDR_POWER, POWER_SLEEP);
        pulse_wake(1'b1);
        drain();
        chk(8'(n), 8'h01);
        chk(lb, ACK_BYTE);
        rd(ADDR_SENSE, SENSE_POLICED);
        {pkt_ready, air_done, chan_busy} = 3'b100;
        wait_tx();
        report_and_stop();
    end
endmodule
bind rcr_config_top rcr_config_asserts #(.NCHAN(NCHAN), .WIN_S(WIN_S)) u_chk (.mclk(mclk),
    .reset(reset), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .pkt_ready(pkt_ready), .chan_busy(chan_busy),
    .chan_index(chan_index), .air_done(air_done), .radio_tx(radio_tx),
    .sense_req(sense_req), .wake(wake), .vol_corrupt(vol_corrupt), .radio_en(radio_en),
    .asleep(asleep), .soft_reset(soft_reset), .rcr_sense_mode(rcr_sense_mode));
`default_nettype wire

// ---- pkg/rcr_pkg.sv ----
package rcr_pkg;
    localparam logic [7:0] HDR_BYTE = 8'hff;
    localparam logic [7:0] SIZE_BYTE = 8'h02;
    localparam logic [7:0] ESC_BYTE = 8'hfe;
    localparam logic [7:0] ACK_BYTE = 8'h06;
    localparam logic [7:0] ADDR_BANNER_NV = 8'h0a;
    localparam logic [7:0] ADDR_SENSE_NV = 8'h0b;
    localparam logic [7:0] ADDR_POWER_NV = 8'h0d;
    localparam logic [7:0] ADDR_SENSE = 8'h56;
    localparam logic [7:0] ADDR_POWER = 8'h58;
    localparam logic [7:0] ADDR_WAKE_ACK = 8'h59;
    localparam logic [7:0] ADDR_WAKE_ACK_NV = 8'h0e;
    localparam logic [7:0] BANNER_OFF = 8'h00;
    localparam logic [7:0] BANNER_ON = 8'h01;
    localparam logic [7:0] SENSE_OFF = 8'h00;
    localparam logic [7:0] SENSE_FREE = 8'h01;
    localparam logic [7:0] SENSE_POLICED = 8'h02;
    localparam logic [7:0] POWER_AWAKE = 8'h00;
    localparam logic [7:0] POWER_SLEEP = 8'h01;
    localparam logic [7:0] BANNER_RST = 8'h01;
    localparam logic [7:0] SENSE_RST = 8'h00;
    localparam logic [7:0] POWER_RST = 8'h00;
    localparam logic [7:0] WAKE_ACK_RST = 8'h01;
    localparam int CLK_HZ = 20_000_000;
    localparam int POLICE_S = 180;
    localparam int BUDGET_MS = 33_300;
    localparam int POLICE_PERIOD_MS = 3_600_000;
    // Budget share of one policing interval, in ms (33.3 s per hour)
    localparam int BUDGET_WIN_MS = BUDGET_MS / (POLICE_PERIOD_MS / (POLICE_S * 1000));
    localparam int MS_CYCLES = CLK_HZ / 1000;
    localparam int TICK_W = 16;
    localparam int MS_W = 20;
    localparam int BANNER_LEN = 8;
    // Arbitrary neutral version text
    localparam logic [8*BANNER_LEN-1:0] BANNER_TEXT = 64'h52_41_44_49_4f_20_30_0d;
endpackage

// ---- pkg/rcr_tx_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface rcr_tx_if;
    logic req;
    logic busy;
    logic clear;
    logic [7:0] slot;
    modport ctrl (output req, output slot, output clear, input busy);
    modport pol (input req, input slot, input clear, output busy);
endinterface
`default_nettype wire

// ---- rtl/rcr_config_top.sv ----
// Overview of operation
// - FF 02 FE addr is a read
// - Read answers 06, address, value
// - FF 02 addr value is a write
// - Banner 00 sends no start-up message
// - Banner 01 sends message after each reset
// - Incoming bytes dropped during banner
// - Banner lives only at non-volatile 0x0a
// - Sensing mode transmits only on free channel
// - Mode 00 transmits at once, unsensed
// - Mode 01 spreads time over free channels
// - Mode 02 caps channel time per interval
// - Power 00 awake, radio usable
// - Power 01 sleep, circuitry disabled
// - Volatile values kept across sleep
// - Corrupted volatile state forces reboot
// - Wake acknowledge follows the banner
`timescale 1ns/1ps
`default_nettype none
module rcr_config_top #(
    parameter int NCHAN = 8,
    parameter int WIN_S = 180
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Host serial byte stream
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    // Radio transmit path
    input wire logic pkt_ready,
    input wire logic chan_busy,
    input wire logic [7:0] chan_index,
    input wire logic air_done,
    output logic radio_tx,
    output logic sense_req,
    // Power and integrity
    input wire logic wake,
    input wire logic vol_corrupt,
    output logic radio_en,
    output logic asleep,
    output logic soft_reset,
    output logic [1:0] rcr_sense_mode
);
    import rcr_pkg::*;

    if (NCHAN < 1 || NCHAN > 256 || WIN_S < 1 || WIN_S > 1048) begin : g_bad_param
        $error("rcr_config_top: unsupported parameters");
    end

    typedef enum {ST_BANNER, ST_WACK, ST_HDR, ST_SIZE, ST_ESC, ST_RADDR, ST_WVAL,
        ST_ACK, ST_RADR_OUT, ST_RVAL} rcr_state_t;
    typedef enum {TX_IDLE, TX_SENSE, TX_ON} rcr_tx_t;

    rcr_state_t st_q;
    rcr_tx_t tx_st_q;
    logic [7:0] banner_nv_q, sense_nv_q, power_nv_q, wack_nv_q;
    logic [7:0] sense_q, power_q, wack_q;
    logic [7:0] addr_q;
    logic [$clog2(BANNER_LEN+1)-1:0] bidx_q;
    logic boot_q;
    logic fire;
    logic policed_busy;
    logic [7:0] slot_q;
    logic [7:0] last_chan_q;
    logic spread_wait_q;
    logic spread_wait;
    logic chan_free;
    rcr_tx_if txi ();

    function automatic logic sense_ok(input logic [7:0] v);
        return v == SENSE_OFF || v == SENSE_FREE || v == SENSE_POLICED;
    endfunction
    function automatic logic bool_ok(input logic [7:0] v);
        return v == 8'h00 || v == 8'h01;
    endfunction
    function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] bn,
        input logic [7:0] sn, input logic [7:0] pn, input logic [7:0] wn,
        input logic [7:0] s, input logic [7:0] p, input logic [7:0] w);
        case (a)
            ADDR_BANNER_NV: return bn;
            ADDR_SENSE_NV: return sn;
            ADDR_POWER_NV: return pn;
            ADDR_WAKE_ACK_NV: return wn;
            ADDR_SENSE: return s;
            ADDR_POWER: return p;
            ADDR_WAKE_ACK: return w;
            default: return 8'h00;
        endcase
    endfunction

    assign fire = !tx_valid || tx_ready;
    assign policed_busy = txi.busy;
    assign chan_free = !chan_busy && !(sense_q == SENSE_POLICED && policed_busy);
    // Free mode: the last channel used yields one sense cycle to the others
    assign spread_wait = sense_q == SENSE_FREE && chan_index == last_chan_q && !spread_wait_q;

    // Frame parser and reply sequencer
    always_ff @(posedge mclk) begin
        if (reset || soft_reset) begin
            st_q <= ST_BANNER;
            addr_q <= 8'h00;
            bidx_q <= '0;
            boot_q <= 1'b1;
        end else begin
            case (st_q)
                ST_BANNER: begin
                    // rx is ignored here
                    if (boot_q) begin
                        boot_q <= 1'b0;
                        if (banner_nv_q == BANNER_OFF) st_q <= ST_WACK;
                    end else if (fire) begin
                        if (int'(bidx_q) == BANNER_LEN) st_q <= ST_WACK;
                        else bidx_q <= bidx_q + 1'b1;
                    end
                end
                ST_WACK: if (fire) st_q <= ST_HDR;
                ST_HDR: if (rx_valid && rx_data == HDR_BYTE) st_q <= ST_SIZE;
                ST_SIZE: if (rx_valid) st_q <= (rx_data == SIZE_BYTE) ? ST_ESC : ST_HDR;
                ST_ESC: if (rx_valid) begin
                    addr_q <= rx_data;
                    st_q <= (rx_data == ESC_BYTE) ? ST_RADDR : ST_WVAL;
                end
                ST_RADDR: if (rx_valid) begin
                    addr_q <= rx_data;
                    st_q <= ST_ACK;
                end
                ST_WVAL: if (rx_valid) st_q <= ST_HDR;
                ST_ACK: if (fire) st_q <= ST_RADR_OUT;
                ST_RADR_OUT: if (fire) st_q <= ST_RVAL;
                ST_RVAL: if (fire) st_q <= ST_HDR;
                default: st_q <= ST_HDR;
            endcase
        end
    end

    // Reply byte stream
    always_ff @(posedge mclk) begin
        if (reset || soft_reset) begin
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
        end else if (fire) begin
            tx_valid <= 1'b0;
            case (st_q)
                ST_BANNER: if (!boot_q && int'(bidx_q) < BANNER_LEN) begin
                    tx_valid <= 1'b1;
                    tx_data <= BANNER_TEXT[8*(BANNER_LEN-1-int'(bidx_q)) +: 8];
                end
                ST_WACK: if (wack_q == 8'h01) begin
                    tx_valid <= 1'b1;
                    tx_data <= ACK_BYTE;
                end
                ST_ACK: begin
                    tx_valid <= 1'b1;
                    tx_data <= ACK_BYTE;
                end
                ST_RADR_OUT: begin
                    tx_valid <= 1'b1;
                    tx_data <= addr_q;
                end
                ST_RVAL: begin
                    tx_valid <= 1'b1;
                    tx_data <= reg_read(addr_q, banner_nv_q, sense_nv_q, power_nv_q,
                        wack_nv_q, sense_q, power_q, wack_q);
                end
                default: tx_valid <= 1'b0;
            endcase
        end
    end

    // Non-volatile bank survives soft reset; only power-on reset loads defaults
    always_ff @(posedge mclk) begin
        if (reset) begin
            banner_nv_q <= BANNER_RST;
            sense_nv_q <= SENSE_RST;
            power_nv_q <= POWER_RST;
            wack_nv_q <= WAKE_ACK_RST;
        end else if (st_q == ST_WVAL && rx_valid) begin
            case (addr_q)
                ADDR_BANNER_NV: if (bool_ok(rx_data)) banner_nv_q <= rx_data;
                ADDR_SENSE_NV: if (sense_ok(rx_data)) sense_nv_q <= rx_data;
                ADDR_POWER_NV: if (bool_ok(rx_data)) power_nv_q <= rx_data;
                ADDR_WAKE_ACK_NV: if (bool_ok(rx_data)) wack_nv_q <= rx_data;
                default: ;
            endcase
        end
    end

    // Volatile bank reloads from the non-volatile bank on soft reset; power-on reset loads the defaults
    always_ff @(posedge mclk) begin
        if (reset) begin
            sense_q <= SENSE_RST;
            power_q <= POWER_RST;
            wack_q <= WAKE_ACK_RST;
        end else if (soft_reset) begin
            sense_q <= sense_nv_q;
            power_q <= power_nv_q;
            wack_q <= wack_nv_q;
        end else if (st_q == ST_WVAL && rx_valid) begin
            case (addr_q)
                ADDR_SENSE: if (sense_ok(rx_data)) sense_q <= rx_data;
                ADDR_POWER: if (bool_ok(rx_data)) power_q <= rx_data;
                ADDR_WAKE_ACK: if (bool_ok(rx_data)) wack_q <= rx_data;
                default: ;
            endcase
        end else if (wake && power_q == POWER_SLEEP) begin
            power_q <= POWER_AWAKE; // Other volatile values held
        end
    end

    // Corrupted volatile state after sleep forces reboot
    always_ff @(posedge mclk) begin
        if (reset) soft_reset <= 1'b0;
        else soft_reset <= wake && power_q == POWER_SLEEP && vol_corrupt;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            radio_en <= 1'b1;
            asleep <= 1'b0;
            rcr_sense_mode <= 2'b00;
        end else begin
            radio_en <= power_q == POWER_AWAKE;
            asleep <= power_q == POWER_SLEEP;
            rcr_sense_mode <= sense_q[1:0];
        end
    end

    // Radio transmit gating
    always_ff @(posedge mclk) begin
        if (reset || soft_reset || power_q != POWER_AWAKE) begin
            tx_st_q <= TX_IDLE;
            radio_tx <= 1'b0;
            sense_req <= 1'b0;
            slot_q <= 8'h00;
            last_chan_q <= 8'h00;
            spread_wait_q <= 1'b0;
        end else begin
            case (tx_st_q)
                TX_IDLE: if (pkt_ready) begin
                    if (sense_q == SENSE_OFF) begin
                        tx_st_q <= TX_ON;
                        radio_tx <= 1'b1;
                    end else begin
                        tx_st_q <= TX_SENSE;
                        sense_req <= 1'b1;
                    end
                end
                TX_SENSE: begin
                    slot_q <= chan_index;
                    if (chan_free && !spread_wait) begin
                        tx_st_q <= TX_ON;
                        radio_tx <= 1'b1;
                        sense_req <= 1'b0;
                        last_chan_q <= chan_index;
                        spread_wait_q <= 1'b0;
                    end else if (chan_free) begin
                        spread_wait_q <= 1'b1;
                    end
                end
                TX_ON: if (air_done) begin
                    tx_st_q <= TX_IDLE;
                    radio_tx <= 1'b0;
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    assign txi.req = radio_tx;
    assign txi.slot = (tx_st_q == TX_SENSE) ? chan_index : slot_q;
    assign txi.clear = sense_q != SENSE_POLICED;

    rcr_duty_police #(.WIN_S(WIN_S), .NCHAN(NCHAN)) u_police (
        .mclk(mclk),
        .reset(reset),
        .tx_on(radio_tx),
        .tx(txi)
    );
endmodule
`default_nettype wire

// ---- rtl/rcr_duty_police.sv ----
`timescale 1ns/1ps
`default_nettype none
module rcr_duty_police
    import rcr_pkg::*;
#(
    parameter int WIN_S = POLICE_S,
    parameter int NCHAN = 8
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic tx_on,
    rcr_tx_if.pol tx
);
    import rcr_pkg::*;
    // Budget scaled to the policing interval actually used
    localparam int BUDGET = BUDGET_WIN_MS * WIN_S / POLICE_S;
    localparam int WIN_MS = WIN_S * 1000;
    if (NCHAN < 1 || NCHAN > 256 || BUDGET < 1 || WIN_MS > 2 ** MS_W) begin : g_bad_param
        $error("rcr_duty_police: unsupported parameters");
    end
    logic [TICK_W-1:0] tick_q;
    logic ms_q;
    logic [MS_W-1:0] win_q;
    logic [MS_W-1:0] used_q [NCHAN];
    logic [7:0] chan;
    assign chan = (int'(tx.slot) < NCHAN) ? tx.slot : 8'h00;
    assign tx.busy = used_q[chan % NCHAN] >= MS_W'(BUDGET);

    always_ff @(posedge mclk) begin
        if (reset || tick_q == TICK_W'(MS_CYCLES - 1)) begin
            tick_q <= '0;
        end else begin
            tick_q <= tick_q + 1'b1;
        end
    end
    always_ff @(posedge mclk) begin
        ms_q <= !reset && tick_q == TICK_W'(MS_CYCLES - 1);
    end
    // Channel budgets reload every policing interval
    always_ff @(posedge mclk) begin
        if (reset || tx.clear || (ms_q && win_q == MS_W'(WIN_MS - 1))) begin
            win_q <= '0;
            for (int i = 0; i < NCHAN; i++) used_q[i] <= '0;
        end else if (ms_q) begin
            win_q <= win_q + 1'b1;
            if (tx_on && tx.req && !tx.busy) used_q[chan % NCHAN] <= used_q[chan % NCHAN] + 1'b1;
        end
    end
endmodule
`default_nettype wire
